/* File: amd_alu.sv */
`include "amd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: 16-bit add, subtract, shift, logic unit
// RL2: Arithmetic is two's complement by default
// RL3: Each operation updates only its own flags
// RL4: Subtract carry flags mean no borrow
// RL5: Byte or word width per instruction
// RL6: Operands from registers or data memory
// RL7: Results to registers or data memory
// RL8: One 17x17 signed multiply array
// RL9: Signed, unsigned, mixed, literal, byte multiplies
// RL10: Signed and unsigned 32/16, 16/16 divide
// RL11: Quotient to register zero, remainder one
// RL12: Any divisor, even pair dividend
// RL13: One quotient bit per divisor bit
// RL14: Barrel shift up to fifteen bits
// RL15: Arithmetic right, logical right, left shifts
// RL16: Multi-bit shifts refuse memory operands
// RL17: Half carry from bit three or seven
// RL18: Overflow flags signed width overflow
// RL19: Carry flags carry out of msb
// RL20: Divide takes nineteen cycles, pausable
// RL21: Zero fill, arithmetic right copies sign
module amd_alu import amd_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Operation request
    input wire logic op_valid,
    input wire amd_op_t op_code,
    input wire amd_mul_t mul_mode,
    input wire logic byte_mode,
    input wire logic [4:0] lit5,
    // Operand A
    input wire logic a_from_mem,
    input wire logic [15:0] a_reg,
    input wire logic [15:0] a_mem,
    // Operand B
    input wire logic b_from_mem,
    input wire logic [15:0] b_reg,
    input wire logic [15:0] b_mem,
    // Divide control
    input wire logic [15:0] div_hi,
    input wire logic div_long,
    input wire logic div_signed,
    input wire logic div_hold,
    // Destination select
    input wire logic dst_to_mem,
    input wire logic [3:0] dst_reg,
    // Low result write
    output logic wr_reg_we,
    output logic wr_mem_we,
    output logic wr_byte,
    output logic [3:0] wr_addr,
    output logic [15:0] wr_data,
    // High result write
    output logic hi_we,
    output logic [3:0] hi_addr,
    output logic [15:0] hi_data,
    // Status
    output logic busy,
    output logic op_refused,
    output logic div_done,
    output logic [15:0] alu_flags_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Sign bit of the active width
    function automatic logic msb_of(input logic [15:0] v, input logic bm);
        return bm ? v[7] : v[15];
    endfunction : msb_of

    // Zero test of the active width
    function automatic logic zero_of(input logic [15:0] v, input logic bm);
        return bm ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endfunction : zero_of

    // Flags touched per op: {dc, n, ov, z, c}
    function automatic logic [4:0] flag_mask(input amd_op_t op);
        case (op)
            OP_ADD, OP_SUB: return 5'h1F;
            OP_AND, OP_IOR, OP_XOR: return 5'h0A;
            OP_ASR1, OP_LSR1, OP_SL1: return 5'h0B;
            OP_ASRN, OP_LSRN, OP_SLN: return 5'h0A;
            default: return 5'h00;
        endcase
    endfunction : flag_mask

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    logic busy_reg; // Divide in progress
    logic [15:0] opa; // Selected operand A
    logic [15:0] opb; // Selected operand B
    logic is_sub; // Subtract
    logic is_multi; // Multi-bit shift
    logic is_single; // One-bit shift
    logic refuse_mem; // Multi shift with memory
    logic op_take; // Request accepted
    logic alu_take; // Accepted single-cycle op
    logic div_take; // Accepted divide

    assign opa = a_from_mem ? a_mem : a_reg; // RL6
    assign opb = b_from_mem ? b_mem : b_reg; // RL6
    assign is_sub = (op_code == OP_SUB);
    assign is_multi = (op_code == OP_ASRN) || (op_code == OP_LSRN) || (op_code == OP_SLN);
    assign is_single = (op_code == OP_ASR1) || (op_code == OP_LSR1) || (op_code == OP_SL1);
    assign refuse_mem = is_multi && (a_from_mem || dst_to_mem); // RL16
    // Busy only while dividing; the decoder must wait
    assign op_take = op_valid && !busy_reg && !refuse_mem;
    assign alu_take = op_take && (op_code != OP_DIV);
    assign div_take = op_take && (op_code == OP_DIV);

    // ----------------------------------------
    // Adder
    // ----------------------------------------
    logic [15:0] opb_x; // B, inverted for subtract
    logic [16:0] sum_w; // Word sum with carry
    logic [8:0] sum_lo; // Low byte sum
    logic [4:0] sum_nib; // Low nibble sum
    logic add_c; // Carry / not-borrow
    logic add_dc; // Half carry / not-borrow
    logic add_ov; // Signed overflow

    // Subtract is A + ~B + 1, so carry set means no borrow
    assign opb_x = is_sub ? ~opb : opb; // RL4
    assign sum_w = {1'b0, opa} + {1'b0, opb_x} + {16'h0000, is_sub}; // RL1 RL2
    assign sum_lo = {1'b0, opa[7:0]} + {1'b0, opb_x[7:0]} + {8'h00, is_sub};
    assign sum_nib = {1'b0, opa[3:0]} + {1'b0, opb_x[3:0]} + {4'h0, is_sub};
    assign add_c = byte_mode ? sum_lo[8] : sum_w[16]; // RL19 RL5
    assign add_dc = byte_mode ? sum_nib[4] : sum_lo[8]; // RL17
    assign add_ov = (msb_of(opa, byte_mode) == msb_of(opb_x, byte_mode)) &&
                    (msb_of(sum_w[15:0], byte_mode) != msb_of(opa, byte_mode)); // RL18

    // ----------------------------------------
    // Shifter
    // ----------------------------------------
    amd_shdir_t sh_dir; // Direction
    logic [3:0] sh_amt; // Distance
    logic [15:0] sh_res; // Shifted value
    logic sh_c; // Bit shifted out, single shifts

    assign sh_dir = (op_code == OP_SL1 || op_code == OP_SLN) ? SH_LEFT :
                    (op_code == OP_ASR1 || op_code == OP_ASRN) ? SH_ARITH_R : SH_LOGIC_R; // RL15
    assign sh_amt = is_single ? `AMD_SHAMT_ONE : lit5[3:0]; // RL14
    assign sh_c = (sh_dir == SH_LEFT) ? msb_of(opa, byte_mode) : opa[0];

    amd_shifter u_shifter (
        .sh_in(opa),
        .sh_amt(sh_amt),
        .sh_dir(sh_dir),
        .sh_byte(byte_mode),
        .sh_out(sh_res)
    );

    // ----------------------------------------
    // Multiplier
    // ----------------------------------------
    logic [16:0] mul_a; // Extended A
    logic [16:0] mul_b; // Extended B
    logic signed [33:0] mul_p; // Full product

    // Sign or zero extension to 17 bits lets one signed array serve all modes
    assign mul_a = (mul_mode == MUL_SS || mul_mode == MUL_SLIT) ? {opa[15], opa} :
                   (mul_mode == MUL_BYTE) ? {9'h000, opa[7:0]} : {1'b0, opa}; // RL9
    assign mul_b = (mul_mode == MUL_SS || mul_mode == MUL_US) ? {opb[15], opb} :
                   (mul_mode == MUL_SLIT || mul_mode == MUL_ULIT) ? {12'h000, lit5} :
                   (mul_mode == MUL_BYTE) ? {9'h000, opb[7:0]} : {1'b0, opb}; // RL9
    assign mul_p = $signed(mul_a) * $signed(mul_b); // RL8

    // ----------------------------------------
    // Result and flag selection
    // ----------------------------------------
    logic [15:0] res; // Low result
    logic [15:0] res_out; // Byte ops except multiply keep upper byte of A
    logic [4:0] fm; // Flags affected
    logic new_c; // Carry candidate
    logic [15:0] flags_next; // Next flag word

    assign res = (op_code == OP_ADD || is_sub) ? sum_w[15:0] :
                 (op_code == OP_AND) ? (opa & opb) :
                 (op_code == OP_IOR) ? (opa | opb) :
                 (op_code == OP_XOR) ? (opa ^ opb) :
                 (op_code == OP_MUL) ? mul_p[15:0] : sh_res; // RL1
    assign res_out = (byte_mode && op_code != OP_MUL) ? {opa[15:8], res[7:0]} : res; // RL5
    assign fm = flag_mask(op_code);
    assign new_c = is_single ? sh_c : add_c; // RL19

    // Untouched flags hold their value
    always_comb begin
        flags_next = alu_flags_word;
        if (fm[0]) begin
            flags_next[`AMD_FLG_C] = new_c; // RL3
        end
        if (fm[1]) begin
            flags_next[`AMD_FLG_Z] = zero_of(res, byte_mode); // RL3
        end
        if (fm[2]) begin
            flags_next[`AMD_FLG_OV] = add_ov; // RL3
        end
        if (fm[3]) begin
            flags_next[`AMD_FLG_N] = msb_of(res, byte_mode); // RL3
        end
        if (fm[4]) begin
            flags_next[`AMD_FLG_DC] = add_dc; // RL3
        end
    end

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    amd_dstate_t dstate_reg; // Divider state
    logic [16:0] rem_reg; // Partial remainder
    logic [15:0] quo_reg; // Dividend low / quotient
    logic [15:0] dv_reg; // Divisor
    logic [3:0] cnt_reg; // Quotient bit count
    logic sgn_reg; // Signed divide
    logic qneg_reg; // Quotient negative
    logic rneg_reg; // Remainder negative
    logic ov_reg; // Divide overflow
    logic [31:0] dd_raw; // Dividend as captured
    logic [31:0] dd_mag; // Dividend magnitude
    logic [15:0] dv_mag; // Divisor magnitude
    logic [16:0] shifted; // Remainder with next bit
    logic [17:0] trial; // Trial subtract
    logic fits; // Trial did not borrow
    logic q_ovf; // Signed quotient too large
    logic step; // Divider advances

    assign dd_raw = {rem_reg[15:0], quo_reg};
    assign dd_mag = (sgn_reg && dd_raw[31]) ? 32'(-dd_raw) : dd_raw; // RL10
    assign dv_mag = (sgn_reg && dv_reg[15]) ? 16'(-dv_reg) : dv_reg; // RL10
    assign shifted = {rem_reg[15:0], quo_reg[15]};
    assign trial = {1'b0, shifted} - {2'b00, dv_reg};
    assign fits = !trial[17];
    assign q_ovf = sgn_reg && (qneg_reg ? (quo_reg > `AMD_SQ_NEG_MAX) : (quo_reg > `AMD_SQ_POS_MAX));
    // Hold pauses at a cycle boundary; the divide resumes where it stopped
    assign step = !div_hold; // RL20

    // Divider sequencing; sign fixing is done on magnitudes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dstate_reg <= ST_IDLE;
            rem_reg <= 17'h00000;
            quo_reg <= 16'h0000;
            dv_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            sgn_reg <= 1'b0;
            qneg_reg <= 1'b0;
            rneg_reg <= 1'b0;
            ov_reg <= 1'b0;
        end else begin
            case (dstate_reg)
                ST_IDLE: begin
                    if (div_take) begin
                        // Long dividend comes from an even pair, high half odd
                        rem_reg <= {1'b0, div_long ? div_hi :
                                    {16{div_signed && opa[15]}}}; // RL12
                        quo_reg <= opa;
                        dv_reg <= opb; // RL12
                        sgn_reg <= div_signed;
                        dstate_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: if (step) begin
                    rem_reg <= {1'b0, dd_mag[31:16]};
                    quo_reg <= dd_mag[15:0];
                    dv_reg <= dv_mag;
                    // High half not below divisor cannot fit; covers zero divisor
                    ov_reg <= (dd_mag[31:16] >= dv_mag);
                    qneg_reg <= sgn_reg && (dd_raw[31] ^ dv_reg[15]);
                    rneg_reg <= sgn_reg && dd_raw[31];
                    cnt_reg <= 4'h0;
                    dstate_reg <= ST_ITER;
                end
                ST_ITER: if (step) begin
                    rem_reg <= fits ? trial[16:0] : shifted;
                    quo_reg <= {quo_reg[14:0], fits}; // RL13
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == `AMD_DIV_BITS) begin
                        dstate_reg <= ST_FIX;
                    end
                end
                ST_FIX: if (step) begin
                    quo_reg <= qneg_reg ? 16'(-quo_reg) : quo_reg;
                    rem_reg <= {1'b0, rneg_reg ? 16'(-rem_reg[15:0]) : rem_reg[15:0]};
                    ov_reg <= ov_reg || q_ovf;
                    dstate_reg <= ST_WRITE;
                end
                ST_WRITE: if (step) begin
                    dstate_reg <= ST_IDLE;
                end
                default: dstate_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    logic div_fin; // Divider writes this edge

    assign div_fin = (dstate_reg == ST_WRITE) && step;
    assign busy = busy_reg;

    // All outputs are flops; write strobes are one-cycle pulses
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_reg <= 1'b0;
            op_refused <= 1'b0;
            div_done <= 1'b0;
            wr_reg_we <= 1'b0;
            wr_mem_we <= 1'b0;
            wr_byte <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 16'h0000;
            hi_we <= 1'b0;
            hi_addr <= 4'h0;
            hi_data <= 16'h0000;
            alu_flags_word <= `AMD_FLAGS_RST;
        end else begin
            op_refused <= op_valid && (busy_reg || refuse_mem); // RL16
            div_done <= div_fin;
            wr_reg_we <= 1'b0;
            wr_mem_we <= 1'b0;
            hi_we <= 1'b0;
            if (div_take) begin
                busy_reg <= 1'b1;
            end
            if (div_fin) begin
                // Quotient and remainder always land in fixed registers
                busy_reg <= 1'b0;
                wr_reg_we <= 1'b1;
                wr_byte <= 1'b0;
                wr_addr <= `AMD_QUOT_REG; // RL11
                wr_data <= quo_reg;
                hi_we <= 1'b1;
                hi_addr <= `AMD_REM_REG; // RL11
                hi_data <= rem_reg[15:0];
                alu_flags_word[`AMD_FLG_OV] <= ov_reg;
                alu_flags_word[`AMD_FLG_N] <= quo_reg[15];
                alu_flags_word[`AMD_FLG_Z] <= (quo_reg == 16'h0000);
            end else if (alu_take) begin
                // Products always go to registers; byte products write only the even register
                wr_reg_we <= !dst_to_mem || (op_code == OP_MUL); // RL7
                wr_mem_we <= dst_to_mem && (op_code != OP_MUL); // RL7
                wr_byte <= byte_mode && (op_code != OP_MUL);
                wr_addr <= (op_code == OP_MUL) ? {dst_reg[3:1], 1'b0} : dst_reg;
                wr_data <= res_out;
                hi_we <= (op_code == OP_MUL) && (mul_mode != MUL_BYTE);
                hi_addr <= {dst_reg[3:1], 1'b1};
                hi_data <= mul_p[31:16];
                alu_flags_word <= flags_next; // RL3
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [4:0] dcyc_reg; // Advancing cycles since divide start
    logic [16:0] chk_s17; // Sign-extended word sum
    logic signed [15:0] chk_asr; // Reference arithmetic shift

    assign chk_s17 = {opa[15], opa} + {opb[15], opb};
    assign chk_asr = $signed(opa) >>> lit5[3:0];

    // Counts only edges on which the divider moves
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dcyc_reg <= 5'h00;
        end else if (div_take) begin
            dcyc_reg <= 5'h00;
        end else if (busy_reg && step) begin
            dcyc_reg <= dcyc_reg + 5'h01;
        end
    end

    sequence s_div_start;
        div_take;
    endsequence
    sequence s_div_busy;
        busy[*8];
    endsequence

    a_div_cycles: assert property ($rose(div_done) |-> dcyc_reg == `AMD_DIV_CYCLES) // RL20
        else $error("divide did not take nineteen cycles");
    a_div_runs: assert property (s_div_start |=> s_div_busy ##1 busy) // RL20
        else $error("divider dropped busy early");
    a_div_dest: assert property (div_done |-> wr_reg_we && wr_addr == `AMD_QUOT_REG &&
                                 hi_we && hi_addr == `AMD_REM_REG) // RL11
        else $error("divide results not in registers zero and one");
    a_add_word: assert property (alu_take && op_code == OP_ADD && !byte_mode
                                 |=> wr_data == $past(opa) + $past(opb)) // RL1
        else $error("word add result wrong");
    a_sub_carry: assert property (alu_take && is_sub && !byte_mode
                                  |=> alu_flags_word[`AMD_FLG_C] == $past(opa >= opb)) // RL4
        else $error("subtract carry is not inverted borrow");
    a_add_ovf: assert property (alu_take && op_code == OP_ADD && !byte_mode
                                |=> alu_flags_word[`AMD_FLG_OV] == $past(chk_s17[16] ^ chk_s17[15])) // RL18
        else $error("add overflow flag wrong");
    a_byte_hcarry: assert property (alu_take && op_code == OP_ADD && byte_mode
                                    |=> alu_flags_word[`AMD_FLG_DC] ==
                                    $past(({1'b0, opa[3:0]} + {1'b0, opb[3:0]}) > 5'h0F)) // RL17
        else $error("byte half carry wrong");
    a_mul_signed: assert property (alu_take && op_code == OP_MUL && mul_mode == MUL_SS
                                   |=> {hi_data, wr_data} == $past({{16{opa[15]}}, opa}) *
                                   $past({{16{opb[15]}}, opb})) // RL8
        else $error("signed product wrong");
    a_mul_flags: assert property (alu_take && op_code == OP_MUL |=> $stable(alu_flags_word)) // RL3
        else $error("multiply changed flags");
    a_asr_fill: assert property (alu_take && op_code == OP_ASRN && !byte_mode
                                 |=> wr_data == $past(chk_asr)) // RL21
        else $error("arithmetic right shift wrong");
    a_shift_mem: assert property (op_valid && !busy && refuse_mem
                                  |=> op_refused && !wr_mem_we && !wr_reg_we) // RL16
        else $error("multi-bit shift with memory operand not refused");
    a_mem_dest: assert property (alu_take && op_code == OP_AND && dst_to_mem
                                 |=> wr_mem_we && !wr_reg_we) // RL7
        else $error("memory destination not honoured");
endmodule : amd_alu
`default_nettype wire

/* File: amd_defines.svh */
`ifndef AMD_DEFINES_SVH
`define AMD_DEFINES_SVH

// ----------------------------------------
// Datapath widths
// ----------------------------------------
`define AMD_WORD_W 16
`define AMD_DIV_BITS 4'hF

// ----------------------------------------
// Divide timing and fixed destinations
// ----------------------------------------
`define AMD_DIV_CYCLES 5'h13
`define AMD_QUOT_REG 4'h0
`define AMD_REM_REG 4'h1

// ----------------------------------------
// Flag word bit positions and reset value
// ----------------------------------------
`define AMD_FLG_C 0
`define AMD_FLG_Z 1
`define AMD_FLG_OV 2
`define AMD_FLG_N 3
`define AMD_FLG_DC 8
`define AMD_FLAGS_RST 16'h0000

// ----------------------------------------
// Signed quotient limits and one-bit shift amount
// ----------------------------------------
`define AMD_SQ_POS_MAX 16'h7FFF
`define AMD_SQ_NEG_MAX 16'h8000
`define AMD_SHAMT_ONE 4'h1

`endif

/* File: amd_pkg.sv */
// ----------------------------------------
// Shared types
// ----------------------------------------
package amd_pkg;
    // Operations
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
        OP_ASR1, OP_LSR1, OP_SL1,
        OP_ASRN, OP_LSRN, OP_SLN,
        OP_MUL, OP_DIV
    } amd_op_t;
    // Multiply sign modes
    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_BYTE
    } amd_mul_t;
    // Shift directions
    typedef enum logic [1:0] {
        SH_LEFT, SH_LOGIC_R, SH_ARITH_R
    } amd_shdir_t;
    // Divider states
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_ITER, ST_FIX, ST_WRITE
    } amd_dstate_t;
endpackage : amd_pkg

/* File: amd_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
// Single-cycle barrel shifter, four log stages
module amd_shifter import amd_pkg::*; (
    // Operand and control
    input wire logic [15:0] sh_in,
    input wire logic [3:0] sh_amt,
    input wire amd_shdir_t sh_dir,
    input wire logic sh_byte,
    // Result
    output logic [15:0] sh_out
);
    // ----------------------------------------
    // Preparation
    // ----------------------------------------
    logic fill; // Vacated-bit value
    logic right_byte; // Byte right shift uses top lane
    logic [15:0] stg [5]; // Stage outputs

    assign fill = (sh_dir == SH_ARITH_R) && (sh_byte ? sh_in[7] : sh_in[15]); // RL21
    assign right_byte = sh_byte && (sh_dir != SH_LEFT);
    // Byte sits high so the fill enters at bit 7
    assign stg[0] = right_byte ? {sh_in[7:0], 8'h00} : sh_in;

    // ----------------------------------------
    // Shift stages
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_stage
            localparam int unsigned K = 1 << i;
            logic [31:0] ext; // Right shift with fill
            assign ext = {{16{fill}}, stg[i]} >> K;
            assign stg[i+1] = !sh_amt[i] ? stg[i] :
                              (sh_dir == SH_LEFT ? stg[i] << K : ext[15:0]); // RL14
        end
    endgenerate

    assign sh_out = right_byte ? {8'h00, stg[4][15:8]} : stg[4];
endmodule : amd_shifter
`default_nettype wire

/* File: amd_regfile_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Working registers fed by result writes
// ----------------------------------------
module amd_regfile_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Writes from the block
    input wire logic wr_reg_we,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic hi_we,
    input wire logic [3:0] hi_addr,
    input wire logic [15:0] hi_data,
    // Bench read-back
    input wire logic [3:0] rd_sel,
    output logic [15:0] rd_data
);
    logic [15:0] regs [16]; // Register array
    assign rd_data = regs[rd_sel];
    // Both ports land in one edge; pulses stand one cycle only
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 16; i++) regs[i] <= 16'h0000;
        end else begin
            if (wr_reg_we) regs[wr_addr] <= wr_data;
            if (hi_we) regs[hi_addr] <= hi_data;
        end
    end
endmodule : amd_regfile_model
`default_nettype wire

/* File: alu_mul_div_shift_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_mul_div_shift_tb_top import amd_pkg::*; ;
    logic sys_clk, reset_n, op_valid, byte_mode, a_from_mem, b_from_mem;
    logic div_long, div_signed, div_hold, dst_to_mem, wr_reg_we, wr_mem_we;
    logic wr_byte, hi_we, busy, op_refused, div_done;
    amd_op_t op_code;
    amd_mul_t mul_mode;
    logic [4:0] lit5;
    logic [3:0] dst_reg, wr_addr, hi_addr, rd_sel;
    logic [15:0] a_reg, a_mem, b_reg, b_mem, div_hi, wr_data, hi_data;
    logic [15:0] alu_flags_word, rd_data;
    int miscompares, n_checks, n;
    // Expected products of FFFF by 2 (literal 1F) per mode
    logic [15:0] plo [6] = '{16'hFFFE, 16'hFFFE, 16'hFFFE, 16'hFFE1, 16'hFFE1, 16'h01FE};
    logic [15:0] phi [6] = '{16'hFFFF, 16'h0001, 16'h0001, 16'hFFFF, 16'h001E, 16'h0000};
    amd_alu dut(.sys_clk, .reset_n, .op_valid, .op_code, .mul_mode, .byte_mode, .lit5,
        .a_from_mem, .a_reg, .a_mem, .b_from_mem, .b_reg, .b_mem, .div_hi, .div_long,
        .div_signed, .div_hold, .dst_to_mem, .dst_reg, .wr_reg_we, .wr_mem_we, .wr_byte,
        .wr_addr, .wr_data, .hi_we, .hi_addr, .hi_data, .busy, .op_refused, .div_done,
        .alu_flags_word);
    amd_regfile_model partner(.sys_clk, .reset_n, .wr_reg_we, .wr_addr, .wr_data,
        .hi_we, .hi_addr, .hi_data, .rd_sel, .rd_data);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // Memory copies are inverted so a wrong source shows
    task run(input amd_op_t c, input logic [15:0] a, input logic [15:0] b,
             input logic [4:0] k = 5'h00, input logic bm = 1'b0, input logic am = 1'b0,
             input amd_mul_t mm = MUL_SS);
        @(posedge sys_clk);
        op_code <= c;
        a_reg <= a;
        a_mem <= ~a;
        b_reg <= b;
        b_mem <= ~b;
        lit5 <= k;
        byte_mode <= bm;
        a_from_mem <= am;
        b_from_mem <= am;
        dst_to_mem <= am;
        mul_mode <= mm;
        op_valid <= 1'b1;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
    endtask : run
    // Divide with optional one-cycle pause; bounded wait for completion
    task div(input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] dv,
             input logic sg, input logic lg, input logic h, input logic [15:0] q,
             input logic [15:0] r);
        @(posedge sys_clk);
        div_hi <= hi;
        div_signed <= sg;
        div_long <= lg;
        run(OP_DIV, lo, dv);
        chk("busy", 16'h0001, {15'h0000, busy});
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            div_hold <= h && n == 1;
            #1;
        end while (div_done !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            give_verdict();
        end
        chk("div cycles", 16'(19 + h), 16'(n));
        @(posedge sys_clk);
        #1;
        rd_sel = 4'h0;
        #1 chk("quotient", q, rd_data);
        rd_sel = 4'h1;
        #1 chk("remainder", r, rd_data);
        chk("div ovf", 16'h0000, {15'h0000, alu_flags_word[2]});
    endtask : div
    initial begin
        {op_valid, byte_mode, a_from_mem, b_from_mem, div_long, div_signed} = '0;
        {div_hold, dst_to_mem, lit5, a_reg, a_mem, b_reg, b_mem, div_hi} = '0;
        op_code = OP_ADD;
        mul_mode = MUL_SS;
        dst_reg = 4'h4;
        rd_sel = 4'h0;
        reset_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        run(OP_ADD, 16'h7FFF, 16'h0001);
        chk("sum", 16'h8000, wr_data);
        chk("add flags", 16'h010C, alu_flags_word);
        run(OP_SUB, 16'h0005, 16'h0003);
        chk("sub flags", 16'h0101, alu_flags_word);
        run(OP_ADD, 16'h12FF, 16'h0001, 5'h00, 1'b1);
        chk("byte sum", 16'h1200, wr_data);
        chk("byte flags", 16'h0103, alu_flags_word);
        run(OP_ASRN, 16'h8000, 16'h0000, 5'h0F);
        chk("asr", 16'hFFFF, wr_data);
        chk("shift flags", 16'h0109, alu_flags_word);
        run(OP_LSRN, 16'h8000, 16'h0000, 5'h0F);
        chk("lsr", 16'h0001, wr_data);
        run(OP_SLN, 16'h0001, 16'h0000, 5'h0F);
        chk("sl", 16'h8000, wr_data);
        run(OP_SLN, 16'h0001, 16'h0000, 5'h0F, 1'b0, 1'b1);
        chk("refused", 16'h0001, {15'h0000, op_refused});
        run(OP_AND, 16'h00F0, 16'h0000, 5'h00, 1'b0, 1'b1);
        chk("mem src", 16'hFF0F, wr_data);
        chk("mem write", 16'h0001, {15'h0000, wr_mem_we});
        run(OP_IOR, 16'h00F0, 16'h0F00);
        chk("ior", 16'h0FF0, wr_data);
        run(OP_XOR, 16'h00FF, 16'h0F0F);
        chk("xor", 16'h0FF0, wr_data);
        run(OP_SL1, 16'h4000, 16'h0000);
        chk("sl1", 16'h8000, wr_data);
        run(OP_ASR1, 16'h0081, 16'h0000, 5'h00, 1'b1);
        chk("asr1 byte", 16'h00C0, wr_data);
        chk("shift carry", 16'h0001, {15'h0000, alu_flags_word[0]});
        chk("byte lane", 16'h0001, {15'h0000, wr_byte});
        for (int i = 0; i < 6; i++) begin
            run(OP_MUL, 16'hFFFF, 16'h0002, 5'h1F, 1'b0, 1'b0, amd_mul_t'(i));
            chk("product low", plo[i], wr_data);
            if (i < 5) chk("product high", phi[i], hi_data);
            chk("pair regs", 16'h0045, {8'h00, wr_addr, hi_addr});
            chk("high write", 16'(i < 5), {15'h0000, hi_we});
        end
        div(16'h0000, 16'h0064, 16'h0007, 1'b0, 1'b0, 1'b0, 16'h000E, 16'h0002);
        div(16'hFFFF, 16'hFFF9, 16'h0002, 1'b1, 1'b1, 1'b1, 16'hFFFD, 16'hFFFF);
        div(16'h0001, 16'h0000, 16'h0010, 1'b0, 1'b1, 1'b0, 16'h1000, 16'h0000);
        give_verdict();
    end
endmodule : alu_mul_div_shift_tb_top
`default_nettype wire
